// ### include/sosn_pkg.sv
// constants and carrier types of the sas oob tail and speed negotiation block
// What this block does
// - await-comsas-sent waits for transmitted, carries completed flag to await-no-comsas
// - await-no-comsas goes to sas start on completed or carried flag
// - entering await-comsas starts the comsas detect timeout timer
// - detect timeout without sata support clears mgmt reset, exits to no-comsas timeout
// - comsas detected clears mgmt reset and selector bit, confirms change if was one
// - sata timeout clears mgmt reset, exits to comwake if mgmt reset or no hold
// - sata timeout with spinup hold and mgmt reset zero exits to spinup hold
// - sas start starts rcdt and sets rate: 1.5 first window, else argument
// - sas start and rate-not-supported transmit d.c. idle only
// - rcdt expiry goes to rate-not-supported if unsupported, else await-align
// - rate-not-supported starts sntt and fails when it expires
// - await-align starts sntt and snlt, starts dws, sends align zero repeatedly
// - align zero or one before snlt expiry advance; sntt expiry fails
// - await-align1 sends align one; align one before snlt expiry advances, sntt expiry fails
// - negotiation states may answer dws lost by restarting dws
// - cominit, or dws lost without restart, returns to the cominit state
// - await-snw sends align one, confirms sl_ir receiver start in final window
// - await-snw passes on sntt expiry or stop sntt request
// - pass restarts at next rate unless final, then goes phy ready
// - fail at maximum or final window returns to await-comx
// - fail reruns earlier good rate as final, else next higher rate
// - align received counts only at the rate last set on the transmitter
package sosn_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_NS = 25;
    localparam int unsigned RCDT_NS = 500000;
    localparam int unsigned SNTT_NS = 100000;
    localparam int unsigned SNLT_NS = 50000;
    localparam int unsigned CSTMO_NS = 20000;
    localparam int unsigned RCDT_CYC = (RCDT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SNTT_CYC = (SNTT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SNLT_CYC = (SNLT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CSTMO_CYC = (CSTMO_NS + CLK_NS - 1) / CLK_NS;
    // ==========================================================
    // register map and fields
    localparam logic [2:0] A_CTL = 3'h0;
    localparam logic [2:0] A_SUPP = 3'h1;
    localparam logic [2:0] A_CMD = 3'h2;
    localparam logic [2:0] A_STAT = 3'h3;
    localparam logic [2:0] A_WIN = 3'h4;
    localparam int unsigned F_SATA = 0;
    localparam int unsigned F_HOLD = 1;
    localparam int unsigned F_RETRY = 2;
    localparam int unsigned F_MAXLO = 4;
    localparam int unsigned F_MGMT = 0;
    localparam logic [7:0] CTL_RST = 8'h14;
    localparam logic [3:0] SUPP_RST = 4'h3;
    localparam logic [1:0] RATE_G1 = 2'h0;
    // ==========================================================
    // types
    typedef enum logic [3:0] {
        ST_IDLE, ST_SENT, ST_NOCS, ST_AWCS, ST_START, ST_RNS,
        ST_AL0, ST_AL1, ST_SNW, ST_PASS, ST_FAIL
    } sosn_st_t;
    typedef enum logic [1:0] {EN_SENT, EN_NOCS, EN_AWCS} sosn_ent_t;
    typedef enum logic [2:0] {
        EX_COMINIT, EX_AWCOMX, EX_NOCSTMO, EX_SASRDY, EX_COMWAKE, EX_HOLD
    } sosn_exit_t;
    typedef struct packed {
        logic valid;
        sosn_ent_t target;
    } sosn_enter_t;
    typedef struct packed {
        logic cominit_det;
        logic comsas_det;
        logic comsas_done;
        logic comsas_sent;
        logic align0;
        logic align1;
        logic [1:0] rate;
        logic dws_lost;
        logic stop_sntt;
    } sosn_rx_t;
    typedef struct packed {
        logic dcidle;
        logic align0;
        logic align1;
        logic set_rate;
        logic [1:0] rate;
        logic start_dws;
    } sosn_tx_t;
    typedef struct packed {
        logic psel_chg;
        logic slir_start;
        logic exit_v;
        sosn_exit_t exit_to;
    } sosn_ll_t;
endpackage : sosn_pkg

// ### src/sosn_fsm.sv
// sas oob tail and speed negotiation state machine with register port
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module sosn_fsm #(
    parameter int unsigned RCDT_CYC = sosn_pkg::RCDT_CYC,
    parameter int unsigned SNTT_CYC = sosn_pkg::SNTT_CYC,
    parameter int unsigned SNLT_CYC = sosn_pkg::SNLT_CYC,
    parameter int unsigned CSTMO_CYC = sosn_pkg::CSTMO_CYC
) (
    input wire logic CLK_I, // core clock
    input wire logic RSTN_I, // async reset, low
    input wire sosn_pkg::sosn_enter_t ENTER_I, // entry from comsas state
    input wire sosn_pkg::sosn_rx_t RX_I, // receiver and link messages
    input wire logic PSEL_SET_I, // selector bit set by oob states
    input wire logic [2:0] ADDR_I, // register address
    input wire logic [7:0] WDATA_I, // write data
    input wire logic WE_I, // write strobe
    input wire logic RE_I, // read strobe
    output logic [7:0] RDATA_O, // read data, cycle after strobe
    output sosn_pkg::sosn_tx_t TX_O, // transmitter and dws messages
    output sosn_pkg::sosn_ll_t LL_O, // link layer messages
    output logic PSEL_O // attached selector bit
);
    // ==========================================================
    // state
    typedef struct packed {
        sosn_pkg::sosn_st_t st;
        logic cmpl;
        logic mgmt;
        logic psel;
        logic [1:0] rate;
        logic final_w;
        logic prev_ok;
        logic [31:0] t;
        logic [31:0] n;
        logic [7:0] ctl;
        logic [3:0] supp;
        logic [7:0] rdata;
        sosn_pkg::sosn_tx_t tx;
        sosn_pkg::sosn_ll_t ll;
    } sosn_state_t;

    sosn_state_t s_q, s_d;

    function automatic logic [31:0] dec(input logic [31:0] c);
        dec = (c != 32'h0) ? c - 32'h1 : 32'h0;
    endfunction : dec

    function automatic logic [31:0] ld(input int unsigned cyc);
        ld = (cyc > 0) ? 32'(cyc - 1) : 32'h0;
    endfunction : ld

    // ==========================================================
    // next state
    logic go, ex, al0, al1, snlt_ok, at_max, fin;
    sosn_pkg::sosn_st_t nxt;
    sosn_pkg::sosn_exit_t ex_to;
    logic [1:0] max_rate;

    always_comb begin
        s_d = s_q;
        go = 1'b0;
        ex = 1'b0;
        nxt = s_q.st;
        ex_to = sosn_pkg::EX_COMINIT;
        s_d.t = dec(s_q.t);
        s_d.n = dec(s_q.n);
        s_d.tx.set_rate = 1'b0;
        s_d.tx.start_dws = 1'b0;
        s_d.ll.psel_chg = 1'b0;
        s_d.ll.slir_start = 1'b0;
        s_d.ll.exit_v = 1'b0;
        s_d.rdata = 8'h0;
        max_rate = s_q.ctl[sosn_pkg::F_MAXLO +: 2];
        at_max = (s_q.rate >= max_rate);
        fin = s_q.final_w | at_max;
        // aligns only count at the rate last set
        al0 = RX_I.align0 && (RX_I.rate == s_q.rate);
        al1 = RX_I.align1 && (RX_I.rate == s_q.rate);
        snlt_ok = (s_q.n != 32'h0);
        case (s_q.st)
            sosn_pkg::ST_IDLE: begin
                if (ENTER_I.valid) begin
                    go = 1'b1;
                    case (ENTER_I.target)
                        sosn_pkg::EN_SENT: nxt = sosn_pkg::ST_SENT;
                        sosn_pkg::EN_NOCS: nxt = sosn_pkg::ST_NOCS;
                        default: nxt = sosn_pkg::ST_AWCS;
                    endcase
                end
            end
            sosn_pkg::ST_SENT: begin
                s_d.cmpl = s_q.cmpl | RX_I.comsas_done;
                if (RX_I.comsas_sent) begin
                    go = 1'b1;
                    nxt = sosn_pkg::ST_NOCS;
                end
            end
            sosn_pkg::ST_NOCS: begin
                if (RX_I.cominit_det) begin
                    ex = 1'b1;
                end else if (RX_I.comsas_done || s_q.cmpl) begin
                    go = 1'b1;
                    nxt = sosn_pkg::ST_START;
                    s_d.rate = sosn_pkg::RATE_G1;
                    s_d.final_w = 1'b0;
                    s_d.prev_ok = 1'b0;
                end
            end
            sosn_pkg::ST_AWCS: begin
                if (RX_I.comsas_det) begin
                    s_d.mgmt = 1'b0;
                    s_d.psel = 1'b0;
                    s_d.ll.psel_chg = s_q.psel;
                    go = 1'b1;
                    nxt = sosn_pkg::ST_NOCS;
                end else if (s_q.t == 32'h0) begin
                    ex = 1'b1;
                    s_d.mgmt = 1'b0;
                    if (!s_q.ctl[sosn_pkg::F_SATA]) begin
                        ex_to = sosn_pkg::EX_NOCSTMO;
                    end else if (s_q.mgmt || !s_q.ctl[sosn_pkg::F_HOLD]) begin
                        ex_to = sosn_pkg::EX_COMWAKE;
                    end else begin
                        ex_to = sosn_pkg::EX_HOLD;
                    end
                end
            end
            sosn_pkg::ST_START: begin
                if (RX_I.cominit_det) begin
                    ex = 1'b1;
                end else if (s_q.t == 32'h0) begin
                    go = 1'b1;
                    nxt = s_q.supp[s_q.rate] ? sosn_pkg::ST_AL0 : sosn_pkg::ST_RNS;
                end
            end
            sosn_pkg::ST_RNS: begin
                if (RX_I.cominit_det) begin
                    ex = 1'b1;
                end else if (s_q.t == 32'h0) begin
                    go = 1'b1;
                    nxt = sosn_pkg::ST_FAIL;
                end
            end
            sosn_pkg::ST_AL0, sosn_pkg::ST_AL1, sosn_pkg::ST_SNW, sosn_pkg::ST_PASS: begin
                if (RX_I.cominit_det) begin
                    ex = 1'b1;
                end else if (RX_I.dws_lost && !s_q.ctl[sosn_pkg::F_RETRY]) begin
                    ex = 1'b1;
                end else begin
                    s_d.tx.start_dws = RX_I.dws_lost;
                    case (s_q.st)
                        sosn_pkg::ST_AL0: begin
                            if (al1 && snlt_ok) begin
                                go = 1'b1;
                                nxt = sosn_pkg::ST_SNW;
                            end else if (al0 && snlt_ok) begin
                                go = 1'b1;
                                nxt = sosn_pkg::ST_AL1;
                            end else if (s_q.t == 32'h0) begin
                                go = 1'b1;
                                nxt = sosn_pkg::ST_FAIL;
                            end
                        end
                        sosn_pkg::ST_AL1: begin
                            if (al1 && snlt_ok) begin
                                go = 1'b1;
                                nxt = sosn_pkg::ST_SNW;
                            end else if (s_q.t == 32'h0) begin
                                go = 1'b1;
                                nxt = sosn_pkg::ST_FAIL;
                            end
                        end
                        sosn_pkg::ST_SNW: begin
                            if (s_q.t == 32'h0 || RX_I.stop_sntt) begin
                                go = 1'b1;
                                nxt = sosn_pkg::ST_PASS;
                            end
                        end
                        default: begin
                            s_d.prev_ok = 1'b1;
                            if (fin) begin
                                ex = 1'b1;
                                ex_to = sosn_pkg::EX_SASRDY;
                            end else begin
                                go = 1'b1;
                                nxt = sosn_pkg::ST_START;
                                s_d.rate = s_q.rate + 2'h1;
                            end
                        end
                    endcase
                end
            end
            sosn_pkg::ST_FAIL: begin
                if (s_q.final_w || at_max) begin
                    ex = 1'b1;
                    ex_to = sosn_pkg::EX_AWCOMX;
                end else if (s_q.prev_ok) begin
                    go = 1'b1;
                    nxt = sosn_pkg::ST_START;
                    s_d.rate = s_q.rate - 2'h1;
                    s_d.final_w = 1'b1;
                end else begin
                    go = 1'b1;
                    nxt = sosn_pkg::ST_START;
                    s_d.rate = s_q.rate + 2'h1;
                end
            end
            default: begin
                ex = 1'b1;
            end
        endcase
        // entry actions of the state being entered
        if (go) begin
            s_d.st = nxt;
            case (nxt)
                sosn_pkg::ST_SENT: s_d.cmpl = 1'b0;
                sosn_pkg::ST_AWCS: s_d.t = ld(CSTMO_CYC);
                sosn_pkg::ST_START: begin
                    s_d.t = ld(RCDT_CYC);
                    s_d.tx.set_rate = 1'b1;
                end
                sosn_pkg::ST_RNS: s_d.t = ld(SNTT_CYC);
                sosn_pkg::ST_AL0: begin
                    s_d.t = ld(SNTT_CYC);
                    s_d.n = ld(SNLT_CYC);
                    s_d.tx.start_dws = 1'b1;
                end
                sosn_pkg::ST_SNW: s_d.ll.slir_start = fin;
                default: begin
                end
            endcase
        end
        if (ex) begin
            s_d.st = sosn_pkg::ST_IDLE;
            s_d.ll.exit_v = 1'b1;
            s_d.ll.exit_to = ex_to;
        end
        // transmitter levels follow the state held next
        s_d.tx.rate = s_d.rate;
        s_d.tx.dcidle = (s_d.st == sosn_pkg::ST_START) || (s_d.st == sosn_pkg::ST_RNS);
        s_d.tx.align0 = (s_d.st == sosn_pkg::ST_AL0);
        s_d.tx.align1 = (s_d.st == sosn_pkg::ST_AL1) || (s_d.st == sosn_pkg::ST_SNW);
        // selector set by other states wins over a clear
        if (PSEL_SET_I) begin
            s_d.psel = 1'b1;
        end
        // register writes
        if (WE_I) begin
            case (ADDR_I)
                sosn_pkg::A_CTL: s_d.ctl = WDATA_I;
                sosn_pkg::A_SUPP: s_d.supp = WDATA_I[3:0];
                sosn_pkg::A_CMD: begin
                    if (WDATA_I[sosn_pkg::F_MGMT]) begin
                        s_d.mgmt = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // register reads, answered next cycle
        if (RE_I) begin
            case (ADDR_I)
                sosn_pkg::A_CTL: s_d.rdata = s_q.ctl;
                sosn_pkg::A_SUPP: s_d.rdata = {4'h0, s_q.supp};
                sosn_pkg::A_STAT: s_d.rdata = {2'h0, s_q.psel, s_q.mgmt, s_q.st};
                sosn_pkg::A_WIN: s_d.rdata = {4'h0, s_q.prev_ok, s_q.final_w, s_q.rate};
                default: s_d.rdata = 8'h0;
            endcase
        end
    end

    // state register
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            s_q <= '0;
            s_q.ctl <= sosn_pkg::CTL_RST;
            s_q.supp <= sosn_pkg::SUPP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA_O = s_q.rdata;
    assign TX_O = s_q.tx;
    assign LL_O = s_q.ll;
    assign PSEL_O = s_q.psel;

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    logic neg_q;
    assign neg_q = s_q.st inside {sosn_pkg::ST_START, sosn_pkg::ST_RNS, sosn_pkg::ST_AL0,
        sosn_pkg::ST_AL1, sosn_pkg::ST_SNW, sosn_pkg::ST_PASS};

    a_idle_in_start: assert property (
        (s_q.st inside {sosn_pkg::ST_START, sosn_pkg::ST_RNS}) |->
        (TX_O.dcidle && !TX_O.align0 && !TX_O.align1))
        else $error("no dc idle in start or unsupported rate");
    a_first_rate: assert property (
        (s_q.st == sosn_pkg::ST_NOCS && !RX_I.cominit_det && RX_I.comsas_done) |=>
        (s_q.st == sosn_pkg::ST_START && TX_O.set_rate && TX_O.rate == sosn_pkg::RATE_G1))
        else $error("first window not set to lowest rate");
    a_cominit_exit: assert property (
        (neg_q && RX_I.cominit_det) |=>
        (LL_O.exit_v && LL_O.exit_to == sosn_pkg::EX_COMINIT && s_q.st == sosn_pkg::ST_IDLE))
        else $error("cominit did not return to cominit state");
    a_comsas_clear: assert property (
        (s_q.st == sosn_pkg::ST_AWCS && RX_I.comsas_det && !PSEL_SET_I && !WE_I) |=>
        (!s_q.mgmt && !PSEL_O && LL_O.psel_chg == $past(s_q.psel)
        && s_q.st == sosn_pkg::ST_NOCS))
        else $error("comsas detect did not clear selector state");
    a_snw_pass: assert property (
        (s_q.st == sosn_pkg::ST_SNW && RX_I.stop_sntt && !RX_I.cominit_det && !RX_I.dws_lost)
        |=> (s_q.st == sosn_pkg::ST_PASS))
        else $error("stop sntt did not pass the window");
    a_pass_final: assert property (
        (s_q.st == sosn_pkg::ST_PASS && s_q.final_w && !RX_I.cominit_det && !RX_I.dws_lost)
        |=> (LL_O.exit_v && LL_O.exit_to == sosn_pkg::EX_SASRDY))
        else $error("final pass did not reach phy ready");
    a_fail_final: assert property (
        (s_q.st == sosn_pkg::ST_FAIL && s_q.final_w) |=>
        (LL_O.exit_v && LL_O.exit_to == sosn_pkg::EX_AWCOMX))
        else $error("final failure did not return to await comx");
    a_rate_gate: assert property (
        (s_q.st == sosn_pkg::ST_AL0 && RX_I.rate != s_q.rate && !RX_I.cominit_det
        && !RX_I.dws_lost && s_q.t != 32'h0) |=> (s_q.st == sosn_pkg::ST_AL0))
        else $error("align at wrong rate was accepted");
    a_align_entry: assert property (
        (s_q.st == sosn_pkg::ST_AL0 && $past(s_q.st) == sosn_pkg::ST_START) |->
        (TX_O.start_dws && TX_O.align0 && s_q.t == ld(SNTT_CYC) && s_q.n == ld(SNLT_CYC)))
        else $error("await align entry actions missing");
    a_rcdt_wait: assert property (
        (s_q.st == sosn_pkg::ST_START && s_q.t != 32'h0 && !RX_I.cominit_det) |=>
        (s_q.st == sosn_pkg::ST_START))
        else $error("left sas start before rcdt expiry");

    c_sas_ready: cover property (LL_O.exit_v && LL_O.exit_to == sosn_pkg::EX_SASRDY);
    c_fail_exit: cover property (LL_O.exit_v && LL_O.exit_to == sosn_pkg::EX_AWCOMX);
    c_second_win: cover property (TX_O.set_rate && TX_O.rate != sosn_pkg::RATE_G1);
    c_slir: cover property (LL_O.slir_start);
endmodule : sosn_fsm
`default_nettype wire

// ### test/sosn_peer.sv
// attached phy model answering the speed negotiation windows
`timescale 1ns/10ps
`default_nettype none
module sosn_peer (
    input wire logic clk_i, // core clock
    input wire logic rstn_i, // reset, low
    input wire sosn_pkg::sosn_tx_t tx_i, // local transmitter
    input wire logic mute_i, // never answer
    input wire logic [3:0] dly_i, // answer delay
    output logic a0_o, // align zero pulse
    output logic a1_o, // align one pulse
    output logic [1:0] rate_o // rate of the align
);
    // ==========================================================
    // answer logic
    logic [1:0] rt_q;
    logic [1:0] st_q;
    logic [3:0] cnt_q;
    // one align zero per window, then one align one once ours is seen
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rt_q <= 2'h0;
            st_q <= 2'h0;
            cnt_q <= 4'h0;
            a0_o <= 1'b0;
            a1_o <= 1'b0;
        end else begin
            a0_o <= 1'b0;
            a1_o <= 1'b0;
            if (tx_i.set_rate) begin
                rt_q <= tx_i.rate;
                st_q <= 2'h0;
                cnt_q <= 4'h0;
            end else if (!mute_i && st_q == 2'h0 && tx_i.align0) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q >= dly_i) begin
                    a0_o <= 1'b1;
                    st_q <= 2'h1;
                end
            end else if (!mute_i && st_q == 2'h1 && tx_i.align1) begin
                a1_o <= 1'b1;
                st_q <= 2'h2;
            end
        end
    end
    // rate line shows junk outside an align
    assign rate_o = (a0_o || a1_o) ? rt_q : ~rt_q;
endmodule : sosn_peer
`default_nettype wire

// ### test/sosn_fsm_tb.sv
// self-checking bench of the oob tail and speed negotiation machine
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module sosn_fsm_tb;
    // ==========================================================
    // signals
    logic CLK_I = 0, RSTN_I = 0, PSEL_SET_I = 0, WE_I = 0, RE_I = 0;
    logic [2:0] ADDR_I = 0;
    logic [7:0] WDATA_I = 0, RDATA_O;
    sosn_pkg::sosn_enter_t ENTER_I = '0;
    sosn_pkg::sosn_rx_t tb_rx = '0, rx_w;
    sosn_pkg::sosn_tx_t TX_O;
    sosn_pkg::sosn_ll_t LL_O;
    logic PSEL_O, p_a0, p_a1, mute = 0, stop_q = 0, stop_en = 0, rd_p = 0;
    logic [1:0] p_rt;
    logic [3:0] dly = 0;
    logic [7:0] qr[$], qs[$], qx[$], e_r, e_s, e_x;
    int errors = 0, n_checks = 0, n_slir = 0, n_psel = 0, n_dws = 0;
    // ==========================================================
    // design and far side
    sosn_fsm #(.RCDT_CYC(20), .SNTT_CYC(40), .SNLT_CYC(10), .CSTMO_CYC(8)) u_dut (
        .CLK_I(CLK_I), .RSTN_I(RSTN_I), .ENTER_I(ENTER_I), .RX_I(rx_w),
        .PSEL_SET_I(PSEL_SET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WE_I(WE_I),
        .RE_I(RE_I), .RDATA_O(RDATA_O), .TX_O(TX_O), .LL_O(LL_O), .PSEL_O(PSEL_O));
    sosn_peer u_peer (.clk_i(CLK_I), .rstn_i(RSTN_I), .tx_i(TX_O), .mute_i(mute),
        .dly_i(dly), .a0_o(p_a0), .a1_o(p_a1), .rate_o(p_rt));
    // merge bench pulses with the peer aligns
    always_comb begin
        rx_w = tb_rx;
        rx_w.align0 = p_a0;
        rx_w.align1 = p_a1 | tb_rx.align1; // bench may inject a stray align
        rx_w.rate = p_rt;
        rx_w.stop_sntt = stop_q;
    end
    // 40 mhz clock
    always #12.5 CLK_I = ~CLK_I;
    // ==========================================================
    // monitor: oldest note against each result
    always @(posedge CLK_I) begin
        stop_q <= 1'b0;
        // notes are taken off once; an empty queue gives a value that never matches
        if (rd_p) begin
            e_r = (qr.size() > 0) ? qr.pop_front() : 8'hff;
            `CHK(RDATA_O, e_r)
        end
        rd_p <= RE_I;
        if (TX_O.set_rate) begin
            e_s = (qs.size() > 0) ? qs.pop_front() : 8'hff;
            `CHK({TX_O.dcidle, 5'h0, TX_O.rate}, 8'h80 | e_s)
        end
        if (LL_O.exit_v) begin
            e_x = (qx.size() > 0) ? qx.pop_front() : 8'hff;
            `CHK(8'(LL_O.exit_to), e_x)
        end
        if (LL_O.slir_start) begin
            n_slir++;
            stop_q <= stop_en;
        end
        if (LL_O.psel_chg) n_psel++;
        if (TX_O.start_dws) n_dws++;
    end
    // ==========================================================
    // bus and message tasks
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WE_I <= 1'b1;
        @(posedge CLK_I);
        WE_I <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge CLK_I);
        ADDR_I <= a;
        RE_I <= 1'b1;
        qr.push_back(e);
        @(posedge CLK_I);
        RE_I <= 1'b0;
    endtask : rd
    task automatic px(input sosn_pkg::sosn_rx_t m);
        @(posedge CLK_I);
        tb_rx <= m;
        @(posedge CLK_I);
        tb_rx <= '0;
    endtask : px
    task automatic enter(input sosn_pkg::sosn_ent_t t);
        @(posedge CLK_I);
        ENTER_I <= '{valid: 1'b1, target: t};
        @(posedge CLK_I);
        ENTER_I <= '0;
    endtask : enter
    task automatic drain(input string nm);
        for (int i = 0; i < 3000 && (qx.size() + qs.size() + qr.size()) > 0; i++)
            @(posedge CLK_I);
        `CHK(qx.size() + qs.size() + qr.size(), 0)
        $display("test %s done", nm);
    endtask : drain
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    // hang guard
    initial begin
        repeat (30000) @(posedge CLK_I);
        errors++;
        stop_test;
    end
    // ==========================================================
    // main sequence
    initial begin
        sosn_pkg::sosn_rx_t m;
        int k;
        logic [7:0] ctl[4] = '{8'h10, 8'h11, 8'h13, 8'h13};
        logic [7:0] ex[4] = '{8'h2, 8'h4, 8'h5, 8'h4};
        void'($urandom(71958));
        repeat (5) @(posedge CLK_I);
        RSTN_I <= 1'b1;
        rd(sosn_pkg::A_CTL, 8'h14);
        rd(sosn_pkg::A_SUPP, 8'h03);
        rd(3'h7, 8'h00);
        wr(sosn_pkg::A_STAT, 8'($urandom));
        rd(sosn_pkg::A_STAT, 8'h00);
        drain("regs");
        // two windows, second final
        dly <= 4'($urandom % 6);
        stop_en <= 1'b1;
        qs = '{8'h0, 8'h1};
        qx = '{8'h3};
        enter(sosn_pkg::EN_NOCS);
        m = '0; m.comsas_done = 1; px(m);
        drain("pass");
        `CHK(n_slir, 1)
        // unsupported second rate below the maximum, rerun first rate as final
        wr(sosn_pkg::A_CTL, 8'h24);
        wr(sosn_pkg::A_SUPP, 8'h01);
        qs = '{8'h0, 8'h1, 8'h0};
        qx = '{8'h3};
        enter(sosn_pkg::EN_NOCS);
        px(m);
        drain("rns");
        rd(sosn_pkg::A_WIN, 8'h0c);
        // silent peer: both windows fail
        wr(sosn_pkg::A_CTL, 8'h14);
        wr(sosn_pkg::A_SUPP, 8'h03);
        mute <= 1'b1;
        qs = '{8'h0, 8'h1};
        qx = '{8'h1};
        enter(sosn_pkg::EN_NOCS);
        px(m);
        drain("fail");
        // comsas detect timeout branches
        for (int i = 0; i < 4; i++) begin
            wr(sosn_pkg::A_CTL, ctl[i]);
            if (i == 3) wr(sosn_pkg::A_CMD, 8'h01);
            if (i == 3) rd(sosn_pkg::A_STAT, 8'h10);
            qx.push_back(ex[i]);
            enter(sosn_pkg::EN_AWCS);
            drain("timeout");
        end
        rd(sosn_pkg::A_STAT, 8'h00);
        // comsas detected clears selector, then cominit
        @(posedge CLK_I);
        PSEL_SET_I <= 1'b1;
        @(posedge CLK_I);
        PSEL_SET_I <= 1'b0;
        enter(sosn_pkg::EN_AWCS);
        m = '0; m.comsas_det = 1; px(m);
        rd(sosn_pkg::A_STAT, 8'h02);
        `CHK({n_psel[7:0], 7'h0, PSEL_O}, {8'h1, 8'h0})
        qx = '{8'h0};
        m = '0; m.cominit_det = 1; px(m);
        drain("detect");
        // completed before transmitted, then dws loss handling
        wr(sosn_pkg::A_CTL, 8'h14);
        qs = '{8'h0};
        k = n_dws;
        enter(sosn_pkg::EN_SENT);
        m = '0; m.comsas_done = 1; px(m);
        m = '0; m.comsas_sent = 1; px(m);
        for (int i = 0; i < 100 && n_dws < k + 1; i++) @(posedge CLK_I);
        m = '0; m.dws_lost = 1; px(m);
        repeat (2) @(posedge CLK_I);
        `CHK(n_dws - k, 2)
        // align one at a wrong rate must leave the machine in await align
        m = '0; m.align1 = 1; px(m);
        rd(sosn_pkg::A_STAT, 8'h06);
        m = '0; m.dws_lost = 1;
        wr(sosn_pkg::A_CTL, 8'h10);
        qx = '{8'h0};
        px(m);
        drain("dws");
        stop_test;
    end
endmodule : sosn_fsm_tb
`default_nettype wire
